// file: adc_seq_pkg.sv
/*
 * Shared constants for the conversion timing sequencer: timing figures,
 * derived cycle counts, field widths and the phase enumeration.
 * Assumes a single 125 MHz system clock.
 */
package adc_seq_pkg;

    // ********************************
    // Clock and timing figures
    // ********************************
    localparam int SYS_CLK_MHZ = 125;
    localparam int SYS_PERIOD_PS = 8000;
    localparam int ADC_MIN_PERIOD_PS = 33300;  // Shortest converter clock period
    localparam int TOTAL_MIN_NS = 500;         // Shortest whole conversion
    localparam int SOC_DELAY_SYS = 2;          // Trigger to sample window
    localparam int EOC_LOAD_SYS = 2;           // End of conversion to result load
    localparam int IRQ_DELAY_SYS = 2;          // Flag to interrupt request
    localparam int SH_MIN_ADC = 2;
    localparam int SH_MAX_ADC = 32;
    localparam int CONV_ADC = 10;

    // Least divide ratio that keeps the converter clock period >= 33.3 ns
    localparam int ADC_DIV_MIN = (ADC_MIN_PERIOD_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
    // Least total cycles for 500 ns, rounded up
    localparam int TOTAL_MIN_SYS = (TOTAL_MIN_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;

    // ********************************
    // Field widths and resets
    // ********************************
    localparam int DIV_W = 4;
    localparam int ACQ_W = 5;
    localparam int RES_W = 10;
    localparam int CNT_W = 8;
    localparam logic [DIV_W-1:0] DIV_MIN_V = DIV_W'(ADC_DIV_MIN);
    localparam logic [ACQ_W-1:0] ACQ_RESET = 5'h01;
    localparam logic [CNT_W-1:0] SOC_DLY_V = CNT_W'(SOC_DELAY_SYS);
    localparam logic [CNT_W-1:0] EOC_DLY_V = CNT_W'(EOC_LOAD_SYS);
    localparam logic [CNT_W-1:0] IRQ_DLY_V = CNT_W'(IRQ_DELAY_SYS);
    localparam logic [CNT_W-1:0] SH_MIN_V = CNT_W'(SH_MIN_ADC);
    localparam logic [CNT_W-1:0] SH_MAX_V = CNT_W'(SH_MAX_ADC);
    localparam logic [CNT_W-1:0] CONV_V = CNT_W'(CONV_ADC);
    localparam logic [CNT_W-1:0] TOTAL_V = CNT_W'(TOTAL_MIN_SYS);

    // ********************************
    // Sequencer phases
    // ********************************
    typedef enum logic [5:0] {
        PH_IDLE = 6'h01,
        PH_SOC  = 6'h02,
        PH_SH   = 6'h04,
        PH_CONV = 6'h08,
        PH_EOC  = 6'h10,
        PH_PAD  = 6'h20
    } phase_t;

endpackage

// file: adc_clk_div.sv
/*
 * Converter clock divider: emits a one-cycle enable every div_ratio system
 * clocks, never faster than the least legal ratio.
 * Assumes div_ratio is held stable while run is high.
 */
`timescale 1ns/1ps
module adc_clk_div
    import adc_seq_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Control
    input wire logic run,
    input wire logic [DIV_W-1:0] div_ratio,
    // Enable out
    output logic tick
);

    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] ratio_eff;

    // Clamp keeps the converter period at or above its floor
    assign ratio_eff = (div_ratio < DIV_MIN_V) ? DIV_MIN_V : div_ratio;

    // Counter restarts with each run so phases align to the trigger
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= '0;
            tick <= 1'b0;
        end else if (!run) begin
            cnt_reg <= '0;
            tick <= 1'b0;
        end else if (cnt_reg == ratio_eff - 4'h1) begin
            cnt_reg <= '0;
            tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 4'h1;
            tick <= 1'b0;
        end
    end

    logic [DIV_W-1:0] gap_reg;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            gap_reg <= '0;
        end else if (tick) begin
            gap_reg <= 4'h1;
        end else if (gap_reg != 4'hF) begin
            gap_reg <= gap_reg + 4'h1;
        end
    end

    AST_TICK_SPACING: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (tick && gap_reg != '0) |-> gap_reg >= DIV_MIN_V)
        else $error("converter enable faster than allowed");

endmodule

// file: adc_conversion_timing_sequencer.sv
/*
 * Single-conversion timing sequencer: trigger delay, sample/hold window,
 * successive-approximation phase, result load, sticky completion flag and
 * delayed interrupt request.
 * Assumes the analog stage answers on data_in after end of conversion, before the result load, and that
 * control inputs are synchronous to sys_clk.
 */
`timescale 1ns/1ps
module adc_conversion_timing_sequencer
    import adc_seq_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Control (converter_control_one fields)
    input wire logic soc_trigger,
    input wire logic [ACQ_W-1:0] acquisition_prescale_field,
    input wire logic [DIV_W-1:0] adc_clk_ratio,
    input wire logic irq_enable,
    input wire logic flag_clear,
    // Analog stage
    input wire logic [RES_W-1:0] data_in,
    output logic sample_hold,
    output logic converting,
    output logic eoc,
    // Results
    output logic [RES_W-1:0] result_reg,
    output logic done_flag,
    output logic conversion_done_irq,
    output logic busy
);

    // ********************************
    // State and counters
    // ********************************
    phase_t phase_reg;
    phase_t phase_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] total_reg;
    logic [CNT_W-1:0] sh_len;
    logic [CNT_W-1:0] irq_cnt_reg;
    logic tick;
    logic run;
    logic load;

    // Divider starts on the edge that opens the window; a late start adds a cycle to it
    assign run = (phase_next == PH_SH) || (phase_next == PH_CONV);

    // Converter clock enable
    adc_clk_div u_div (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .run(run),
        .div_ratio(adc_clk_ratio),
        .tick(tick)
    );

    // Field value plus one, held inside the legal window range
    always_comb begin
        sh_len = CNT_W'(acquisition_prescale_field) + 8'h01;
        if (sh_len < SH_MIN_V) begin
            sh_len = SH_MIN_V;
        end
        if (sh_len > SH_MAX_V) begin
            sh_len = SH_MAX_V;
        end
    end

    // ********************************
    // Phase sequencing
    // ********************************
    always_comb begin
        phase_next = phase_reg;
        unique case (phase_reg)
            PH_IDLE: if (soc_trigger) phase_next = PH_SOC;
            PH_SOC: if (cnt_reg == SOC_DLY_V - 8'h01) phase_next = PH_SH;
            PH_SH: if (tick && cnt_reg == sh_len - 8'h01) phase_next = PH_CONV;
            PH_CONV: if (tick && cnt_reg == CONV_V - 8'h01) phase_next = PH_EOC;
            PH_EOC: if (cnt_reg == EOC_DLY_V - 8'h01) phase_next = PH_PAD;
            PH_PAD: if (total_reg >= TOTAL_V) phase_next = PH_IDLE;
            default: phase_next = PH_IDLE;
        endcase
    end

    // Load waits at end of padding so the whole sequence meets its floor
    assign load = (phase_reg == PH_PAD) && (phase_next == PH_IDLE);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_reg <= PH_IDLE;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // Phase counter: system clocks in fixed delays, converter ticks otherwise
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= '0;
        end else if (phase_next != phase_reg) begin
            cnt_reg <= '0;
        end else if (phase_reg == PH_SOC || phase_reg == PH_EOC || tick) begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    // Total cycles since trigger, saturating
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            total_reg <= '0;
        end else if (phase_reg == PH_IDLE) begin
            total_reg <= '0;
        end else if (total_reg != 8'hFF) begin
            total_reg <= total_reg + 8'h01;
        end
    end

    // ********************************
    // Outputs to analog stage, plus busy
    // ********************************
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sample_hold <= 1'b0;
            converting <= 1'b0;
            eoc <= 1'b0;
            busy <= 1'b0;
        end else begin
            sample_hold <= (phase_next == PH_SH);
            converting <= (phase_next == PH_CONV);
            eoc <= (phase_reg == PH_CONV) && (phase_next == PH_EOC);
            busy <= (phase_next != PH_IDLE);
        end
    end

    // Result register; data sampled at load, well after end of conversion
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            result_reg <= '0;
        end else if (load) begin
            result_reg <= data_in;
        end
    end

    // Sticky flag; a load in the clearing cycle wins
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            done_flag <= 1'b0;
        end else if (load) begin
            done_flag <= 1'b1;
        end else if (flag_clear) begin
            done_flag <= 1'b0;
        end
    end

    // Request follows flag after fixed delay, gated by enable; a clear drops both together
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_cnt_reg <= '0;
            conversion_done_irq <= 1'b0;
        end else if (!done_flag || load || flag_clear) begin
            irq_cnt_reg <= '0;
            conversion_done_irq <= 1'b0;
        end else begin
            if (irq_cnt_reg != IRQ_DLY_V - 8'h01) begin
                irq_cnt_reg <= irq_cnt_reg + 8'h01;
            end
            conversion_done_irq <= irq_enable && (irq_cnt_reg == IRQ_DLY_V - 8'h01);
        end
    end

    // ********************************
    // Checks
    // ********************************
    logic [CNT_W-1:0] sh_ticks_reg;
    logic [CNT_W-1:0] cv_ticks_reg;
    logic [CNT_W-1:0] busy_cyc_reg;

    // Window ticks, counted off the strobe itself rather than the phase counter
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sh_ticks_reg <= '0;
        end else if (!sample_hold) begin
            sh_ticks_reg <= '0;
        end else if (tick && sh_ticks_reg != 8'hFF) begin
            sh_ticks_reg <= sh_ticks_reg + 8'h01;
        end
    end

    // Conversion ticks, counted off the converting strobe
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cv_ticks_reg <= '0;
        end else if (!converting) begin
            cv_ticks_reg <= '0;
        end else if (tick && cv_ticks_reg != 8'hFF) begin
            cv_ticks_reg <= cv_ticks_reg + 8'h01;
        end
    end

    // Busy cycles, saturating; saturation still clears the whole-sequence floor
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_cyc_reg <= '0;
        end else if (!busy) begin
            busy_cyc_reg <= '0;
        end else if (busy_cyc_reg != 8'hFF) begin
            busy_cyc_reg <= busy_cyc_reg + 8'h01;
        end
    end

    AST_SOC_DELAY: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (phase_reg == PH_IDLE && soc_trigger) |=> !sample_hold [*2])
        else $error("sample window opened too early");

    AST_SH_RANGE: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $fell(sample_hold) |-> (sh_ticks_reg >= SH_MIN_V && sh_ticks_reg <= SH_MAX_V))
        else $error("sample window length out of range");

    AST_SH_FIELD: assert property (@(posedge sys_clk) disable iff (!arst_n)
        ($fell(sample_hold) && acquisition_prescale_field == 5'h07) |-> sh_ticks_reg == 8'h08)
        else $error("window length does not follow field");

    AST_CONV_LEN: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $fell(converting) |-> cv_ticks_reg >= CONV_V)
        else $error("conversion phase too short");

    AST_EOC_LOAD: assert property (@(posedge sys_clk) disable iff (!arst_n)
        eoc |-> !load [*2])
        else $error("result loaded too soon");

    AST_TOTAL: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $fell(busy) |-> busy_cyc_reg >= TOTAL_V)
        else $error("conversion shorter than minimum");

    AST_IRQ_DELAY: assert property (@(posedge sys_clk) disable iff (!arst_n)
        ($rose(done_flag) && irq_enable) ##1 (done_flag && irq_enable && !load && !flag_clear)
        |=> conversion_done_irq)
        else $error("interrupt not raised two cycles after flag");

    AST_FLAG_STICKY: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (done_flag && !flag_clear) |=> done_flag)
        else $error("flag dropped without clear");

    AST_IRQ_GATE: assert property (@(posedge sys_clk) disable iff (!arst_n)
        conversion_done_irq |-> $past(irq_enable) && done_flag)
        else $error("interrupt without enable or flag");

    COV_FULL: cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(done_flag));
    COV_IRQ: cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(conversion_done_irq));
    COV_CLEAR_SET: cover property (@(posedge sys_clk) disable iff (!arst_n) load && flag_clear);

endmodule

// file: analog_stage_model.sv
/*
 * Behavioural model of the analog stage behind the sequencer: mux,
 * sample/hold and comparator. It answers on data_in after end of conversion.
 * Assumes the strobes come from the sequencer on the same sys_clk.
 */
`timescale 1ns/1ps
module analog_stage_model
    import adc_seq_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Sequencer strobes
    input wire logic sample_hold,
    input wire logic converting,
    input wire logic eoc,
    // Level presented at the input
    input wire logic [RES_W-1:0] level,
    // Result bus
    output logic [RES_W-1:0] data_in
);
    // ********************************
    // Result bus
    // ********************************
    // Bus toggles during the sample window and conversion so a too-early load never sees a stale match
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            data_in <= '0;
        end else if (eoc) begin
            data_in <= level;
        end else if (sample_hold || converting) begin
            data_in <= ~data_in;
        end
    end
endmodule

// file: tb.sv
/*
 * Self-checking testbench for the conversion timing sequencer.
 * Assumes the package, the divider and the analog stage model compile first.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
    $display("unexpected %s: expected %0h seen %0h", nm, e, g); end end
module tb;
    import adc_seq_pkg::*;
    // ********************************
    // Signals
    // ********************************
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic soc_trigger = 1'b0;
    logic [ACQ_W-1:0] acq = '0;
    logic [DIV_W-1:0] ratio = DIV_MIN_V;
    logic irq_enable = 1'b0;
    logic flag_clear = 1'b0;
    logic [RES_W-1:0] level = '0;
    logic [RES_W-1:0] data_in;
    logic [RES_W-1:0] result_reg;
    logic sample_hold, converting, eoc, done_flag, irq, busy;
    int errors = 0;
    int cmp_count = 0;
    int cyc = 0;

    adc_conversion_timing_sequencer dut_u (.sys_clk(sys_clk), .arst_n(arst_n),
        .soc_trigger(soc_trigger), .acquisition_prescale_field(acq),
        .adc_clk_ratio(ratio), .irq_enable(irq_enable), .flag_clear(flag_clear),
        .data_in(data_in), .sample_hold(sample_hold), .converting(converting),
        .eoc(eoc), .result_reg(result_reg), .done_flag(done_flag),
        .conversion_done_irq(irq), .busy(busy));
    analog_stage_model stage_u (.sys_clk(sys_clk), .arst_n(arst_n),
        .sample_hold(sample_hold), .converting(converting), .eoc(eoc),
        .level(level), .data_in(data_in));

    // ********************************
    // Clock and watchdog
    // ********************************
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    // Longest run is a few hundred cycles; this only catches a hang
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            results();
        end
    end

    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ********************************
    // Scenarios
    // ********************************
    // One conversion, with a retrigger while busy that must be ignored
    task automatic run_conv(input logic [ACQ_W-1:0] f, input logic [DIV_W-1:0] r,
                            input logic [RES_W-1:0] v, input logic ie);
        int rr, win, t_sh0, t_sh1, t_cv0, t_cv1, t_eoc, n_eoc, t_done, t_irq, n_sh;
        logic prev_sh;
        logic [RES_W-1:0] res_seen;
        rr = (int'(r) < ADC_DIV_MIN) ? ADC_DIV_MIN : int'(r);
        win = int'(f) + 1;
        win = (win < SH_MIN_ADC) ? SH_MIN_ADC : ((win > SH_MAX_ADC) ? SH_MAX_ADC : win);
        {t_sh0, t_sh1, t_cv0, t_cv1, t_eoc, n_eoc, t_done, t_irq, n_sh} = '0;
        prev_sh = 1'b0;
        res_seen = '0;
        @(posedge sys_clk);
        acq <= f;
        ratio <= r;
        irq_enable <= ie;
        level <= v;
        soc_trigger <= 1'b1;
        @(posedge sys_clk);
        soc_trigger <= 1'b0;
        for (int n = 1; n < 900 && (t_done == 0 || n < t_done + 70); n++) begin
            @(posedge sys_clk);
            soc_trigger <= (n == 6);
            #1;
            if (sample_hold && !prev_sh) n_sh++;
            prev_sh = sample_hold;
            if (sample_hold) begin
                if (t_sh0 == 0) t_sh0 = n;
                t_sh1 = n;
            end
            if (converting) begin
                if (t_cv0 == 0) t_cv0 = n;
                t_cv1 = n;
            end
            if (eoc) begin
                n_eoc++;
                t_eoc = n;
            end
            if (done_flag && t_done == 0) begin
                t_done = n;
                res_seen = result_reg;
            end
            if (irq && t_irq == 0) t_irq = n;
        end
        `CHK("sh_start", SOC_DELAY_SYS, t_sh0)
        `CHK("sh_len", win * rr, t_sh1 - t_sh0 + 1)
        `CHK("sh_windows", 1, n_sh)
        `CHK("conv_len", CONV_ADC * rr, t_cv1 - t_cv0 + 1)
        `CHK("eoc_count", 1, n_eoc)
        `CHK("load_gap", 1'b1, t_done - t_eoc >= EOC_LOAD_SYS)
        `CHK("total", 1'b1, t_done >= TOTAL_MIN_SYS)
        `CHK("result", v, res_seen)
        `CHK("irq_delay", ie ? IRQ_DELAY_SYS : 0, ie ? t_irq - t_done : t_irq)
        `CHK("flag_hold", 2'b10, {done_flag, busy})
        @(posedge sys_clk);
        flag_clear <= 1'b1;
        @(posedge sys_clk);
        flag_clear <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        `CHK("flag_clear", 2'b00, {done_flag, irq})
        $display("test conversion field %0d ratio %0d done", f, r);
    endtask

    // ********************************
    // Main sequence
    // ********************************
    initial begin
        repeat (8) @(posedge sys_clk);
        #1;
        `CHK("reset_outs", 7'h00, {sample_hold, converting, eoc, done_flag, irq, busy, |result_reg})
        @(posedge sys_clk);
        arst_n <= 1'b1;
        $display("test reset done");
        run_conv(5'h01, 4'h5, 10'h2A5, 1'b1);
        run_conv(5'h00, 4'h2, 10'h15A, 1'b0);
        run_conv(5'h1F, 4'h6, 10'h3FF, 1'b1);
        run_conv(5'h07, 4'h9, 10'h001, 1'b1);
        results();
    end
endmodule
